// ### logic/pbacs_pkg.sv
// Package for the power budgeting and access control capability registers.
// Assumes a 32-bit AXI4-Lite master and 12-bit configuration byte addresses.
package pbacs_pkg;

	// Bus widths and response codes.
	localparam int PBACS_ADDR_W = 12;
	localparam logic [1:0] PBACS_RESP_OKAY = 2'h0;
	localparam logic [1:0] PBACS_RESP_SLVERR = 2'h2;

	// Register byte offsets.
	localparam logic [11:0] PBACS_OFF_PB_HDR = 12'h20c;
	localparam logic [11:0] PBACS_OFF_INDEX = 12'h210;
	localparam logic [11:0] PBACS_OFF_VALUE = 12'h214;
	localparam logic [11:0] PBACS_OFF_SYSALLOC = 12'h218;
	localparam logic [11:0] PBACS_OFF_ACS_HDR = 12'h220;
	localparam logic [11:0] PBACS_OFF_ACS_CAP = 12'h224;
	localparam logic [11:0] PBACS_OFF_EGRESS = 12'h228;

	// Capability header fields.
	localparam logic [15:0] PBACS_ID_POWER = 16'h0004;
	localparam logic [15:0] PBACS_ID_ACCESS = 16'h000d;
	localparam logic [3:0] PBACS_CAP_VERSION = 4'h1;
	localparam logic [11:0] PBACS_NEXT_UPSTREAM = 12'h230;
	localparam logic [11:0] PBACS_NEXT_DOWNSTREAM = 12'h220;
	localparam logic [11:0] PBACS_NEXT_ACCESS = 12'h240;

	// Budget entry selection and reported budget fields.
	localparam logic [7:0] PBACS_IDX_D0_MAX = 8'h00;
	localparam logic [7:0] PBACS_IDX_D0_SUSTAINED = 8'h01;
	localparam logic [7:0] PBACS_INDEX_RST = 8'h00;
	localparam logic [7:0] PBACS_BASE_POWER = 8'h04;
	localparam logic [1:0] PBACS_DATA_SCALE = 2'h0;
	localparam logic [2:0] PBACS_PM_SUBSTATE = 3'h0;
	localparam logic [1:0] PBACS_PM_STATE = 2'h0;
	localparam logic [2:0] PBACS_COND_TYPE = 3'h7;
	localparam logic [2:0] PBACS_POWER_RAIL = 3'h2;
	localparam logic PBACS_SYS_ALLOC = 1'b0;

	// Access control capability, enables and egress vector.
	localparam logic [6:0] PBACS_ACS_FLAGS = 7'h7f;
	localparam logic [7:0] PBACS_EGRESS_SIZE = 8'h08;
	localparam int PBACS_ENABLE_LSB = 16;
	localparam logic [6:0] PBACS_ENABLE_RST = 7'h00;
	localparam logic [7:0] PBACS_EGRESS_RST = 8'h00;

	// Signals the bus master drives.
	typedef struct packed {
		logic awvalid;
		logic [11:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [11:0] araddr;
		logic rready;
	} pbacs_axi_req_t;

	// Signals this slave drives.
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pbacs_axi_rsp_t;

	// Whole state of the register block.
	typedef struct packed {
		pbacs_axi_rsp_t rsp;
		logic [11:0] awAddr;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic [7:0] entryIndex;
		logic [6:0] acsEnable;
		logic [7:0] egressVector;
	} pbacs_state_t;

endpackage : pbacs_pkg

// ### logic/pbacs_regs.sv
// Power budgeting and access control capability registers of one switch port.
// Assumes an AXI4-Lite master on core_clk and a fixed port type set at build.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps

// Notes on behaviour
// - Power header identifier reads 0004h, fixed.
// - Power header version reads 1h, fixed.
// - Next pointer 230h upstream, 220h downstream.
// - Writable index selects D0 max or sustained.
// - Other index values report an all-zero budget.
// - Base power field reads 04h watts.
// - Scale, substate and state fields read zero.
// - Condition type 111b, power rail 010b.
// - System allocated flag reads 0b, read-only.
// - Access header 000Dh, version 1h, next 240h.
// - Access registers exist on downstream ports only.
// - Seven capability flags read one, bit7 reserved.
// - Egress vector size field reads 08h.
// - Bits 16 to 22 are writable feature enables.
// - Eight-bit writable egress vector, reset zero.
module pbacs_regs
#(
	parameter bit DOWNSTREAM = 1'b1
)
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Register bus.
	input wire pbacs_pkg::pbacs_axi_req_t axiReq,
	output pbacs_pkg::pbacs_axi_rsp_t axiRsp,
	// Settings for the peer-to-peer routing logic.
	output logic [6:0] acsEnable,
	output logic [7:0] egressVector
);
	import pbacs_pkg::*;

	// Budget word for a supported entry, both entries report the loaded defaults.
	localparam logic [31:0] BUDGET_WORD = {11'h000, PBACS_POWER_RAIL, PBACS_COND_TYPE,
		PBACS_PM_STATE, PBACS_PM_SUBSTATE, PBACS_DATA_SCALE, PBACS_BASE_POWER};

	pbacs_state_t s;
	pbacs_state_t next_s;

	// Word decode, the two low address bits are ignored.
	function automatic logic isAt(logic [11:0] a, logic [11:0] off);
		return a[11:2] == off[11:2];
	endfunction : isAt

	// True for every offset that this block answers.
	function automatic logic isMapped(logic [11:0] a);
		return isAt(a, PBACS_OFF_PB_HDR) || isAt(a, PBACS_OFF_INDEX) ||
			isAt(a, PBACS_OFF_VALUE) || isAt(a, PBACS_OFF_SYSALLOC) ||
			isAt(a, PBACS_OFF_ACS_HDR) || isAt(a, PBACS_OFF_ACS_CAP) ||
			isAt(a, PBACS_OFF_EGRESS);
	endfunction : isMapped

	// Read data of one word; unmapped and reserved bits read zero.
	function automatic logic [31:0] readWord(logic [11:0] a, pbacs_state_t st);
		logic [31:0] d;
		d = 32'h0000_0000;
		if (isAt(a, PBACS_OFF_PB_HDR))
		begin
			// Each port type chains to a different following structure.
			d = {DOWNSTREAM ? PBACS_NEXT_DOWNSTREAM : PBACS_NEXT_UPSTREAM,
				PBACS_CAP_VERSION, PBACS_ID_POWER};
		end
		else if (isAt(a, PBACS_OFF_INDEX))
		begin
			d = {24'h000000, st.entryIndex};
		end
		else if (isAt(a, PBACS_OFF_VALUE))
		begin
			if (st.entryIndex == PBACS_IDX_D0_MAX || st.entryIndex == PBACS_IDX_D0_SUSTAINED)
			begin
				d = BUDGET_WORD;
			end
			else
			begin
				d = 32'h0000_0000;
			end
		end
		else if (isAt(a, PBACS_OFF_SYSALLOC))
		begin
			d = {31'h0000_0000, PBACS_SYS_ALLOC};
		end
		else if (DOWNSTREAM && isAt(a, PBACS_OFF_ACS_HDR))
		begin
			d = {PBACS_NEXT_ACCESS, PBACS_CAP_VERSION, PBACS_ID_ACCESS};
		end
		else if (DOWNSTREAM && isAt(a, PBACS_OFF_ACS_CAP))
		begin
			d = {9'h000, st.acsEnable, PBACS_EGRESS_SIZE, 1'b0, PBACS_ACS_FLAGS};
		end
		else if (DOWNSTREAM && isAt(a, PBACS_OFF_EGRESS))
		begin
			d = {24'h000000, st.egressVector};
		end
		return d;
	endfunction : readWord

	// Next-state logic: bus handshakes and register updates.
	always_comb
	begin
		next_s = s;
		// Address and data are taken independently, in either order.
		if (axiReq.awvalid && s.rsp.awready)
		begin
			next_s.awAddr = axiReq.awaddr;
			next_s.rsp.awready = 1'b0;
		end
		if (axiReq.wvalid && s.rsp.wready)
		begin
			next_s.wData = axiReq.wdata;
			next_s.wStrb = axiReq.wstrb;
			next_s.rsp.wready = 1'b0;
		end
		// Both halves held: perform the write and raise the response.
		if (!s.rsp.awready && !s.rsp.wready && !s.rsp.bvalid)
		begin
			next_s.rsp.bvalid = 1'b1;
			next_s.rsp.bresp = isMapped(s.awAddr) ? PBACS_RESP_OKAY : PBACS_RESP_SLVERR;
			if (isAt(s.awAddr, PBACS_OFF_INDEX) && s.wStrb[0])
			begin
				next_s.entryIndex = s.wData[7:0];
			end
			if (DOWNSTREAM && isAt(s.awAddr, PBACS_OFF_ACS_CAP) && s.wStrb[2])
			begin
				next_s.acsEnable = s.wData[PBACS_ENABLE_LSB +: 7];
			end
			if (DOWNSTREAM && isAt(s.awAddr, PBACS_OFF_EGRESS) && s.wStrb[0])
			begin
				next_s.egressVector = s.wData[7:0];
			end
		end
		// Response taken: reopen both write channels together.
		if (s.rsp.bvalid && axiReq.bready)
		begin
			next_s.rsp.bvalid = 1'b0;
			next_s.rsp.awready = 1'b1;
			next_s.rsp.wready = 1'b1;
		end
		// Read data is sampled at the address handshake, before a same-cycle write lands.
		if (axiReq.arvalid && s.rsp.arready)
		begin
			next_s.rsp.arready = 1'b0;
			next_s.rsp.rvalid = 1'b1;
			next_s.rsp.rdata = readWord(axiReq.araddr, s);
			next_s.rsp.rresp = isMapped(axiReq.araddr) ? PBACS_RESP_OKAY : PBACS_RESP_SLVERR;
		end
		if (s.rsp.rvalid && axiReq.rready)
		begin
			next_s.rsp.rvalid = 1'b0;
			next_s.rsp.arready = 1'b1;
		end
	end

	// State register with the documented reset values.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			s <= '0;
			s.rsp.awready <= 1'b1;
			s.rsp.wready <= 1'b1;
			s.rsp.arready <= 1'b1;
			s.entryIndex <= PBACS_INDEX_RST;
			s.acsEnable <= PBACS_ENABLE_RST;
			s.egressVector <= PBACS_EGRESS_RST;
		end
		else
		begin
			s <= next_s;
		end
	end

	// Outputs come straight from the state flops.
	assign axiRsp = s.rsp;
	assign acsEnable = s.acsEnable;
	assign egressVector = s.egressVector;

	// Checks on what this block drives.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// A read address accepted at this edge.
	sequence s_readAt(logic [11:0] off);
		axiReq.arvalid && s.rsp.arready && isAt(axiReq.araddr, off);
	endsequence

	// The internal write strobe of one register with a byte lane.
	sequence s_writeAt(logic [11:0] off, int lane);
		!s.rsp.awready && !s.rsp.wready && !s.rsp.bvalid && isAt(s.awAddr, off) &&
			s.wStrb[lane];
	endsequence

	// Write strobe for the checks: both halves held and no answer raised yet.
	logic writeDone;
	assign writeDone = !s.rsp.awready && !s.rsp.wready && !s.rsp.bvalid;

	// Any read address accepted at this edge.
	sequence s_readTaken;
		axiReq.arvalid && s.rsp.arready;
	endsequence

	// Read answer standing with the address channel closed.
	sequence s_readHeld;
		s.rsp.rvalid && !s.rsp.arready;
	endsequence

	// Write answer standing with both write channels closed.
	sequence s_writeAnswered;
		s.rsp.bvalid && !s.rsp.awready && !s.rsp.wready;
	endsequence

	property p_powerId;
		s_readAt(PBACS_OFF_PB_HDR) |=> s.rsp.rvalid && s.rsp.rdata[15:0] == PBACS_ID_POWER;
	endproperty
	a_powerId: assert property (p_powerId) else $error("Power header identifier wrong.");

	property p_powerVersion;
		s_readAt(PBACS_OFF_PB_HDR) |=> s.rsp.rdata[19:16] == PBACS_CAP_VERSION;
	endproperty
	a_powerVersion: assert property (p_powerVersion) else $error("Power version wrong.");

	property p_powerNext;
		s_readAt(PBACS_OFF_PB_HDR) |=> s.rsp.rdata[31:20] ==
			(DOWNSTREAM ? PBACS_NEXT_DOWNSTREAM : PBACS_NEXT_UPSTREAM);
	endproperty
	a_powerNext: assert property (p_powerNext) else $error("Power next pointer wrong.");

	property p_indexWrite;
		s_writeAt(PBACS_OFF_INDEX, 0) |=> s.entryIndex == $past(s.wData[7:0]);
	endproperty
	a_indexWrite: assert property (p_indexWrite) else $error("Index write lost.");

	property p_unsupported;
		s_readAt(PBACS_OFF_VALUE) and (s.entryIndex > PBACS_IDX_D0_SUSTAINED) |=>
			s.rsp.rdata == 32'h0000_0000;
	endproperty
	a_unsupported: assert property (p_unsupported) else $error("Unsupported not zero.");

	property p_basePower;
		s_readAt(PBACS_OFF_VALUE) and (s.entryIndex <= PBACS_IDX_D0_SUSTAINED) |=>
			s.rsp.rdata[7:0] == PBACS_BASE_POWER && s.rsp.rdata[14:8] == 7'h00;
	endproperty
	a_basePower: assert property (p_basePower) else $error("Base power wrong.");

	property p_typeRail;
		s_readAt(PBACS_OFF_VALUE) and (s.entryIndex <= PBACS_IDX_D0_SUSTAINED) |=>
			s.rsp.rdata[17:15] == PBACS_COND_TYPE && s.rsp.rdata[20:18] == PBACS_POWER_RAIL;
	endproperty
	a_typeRail: assert property (p_typeRail) else $error("Type or rail field wrong.");

	property p_sysAlloc;
		s_readAt(PBACS_OFF_SYSALLOC) |=> s.rsp.rdata == {31'h0000_0000, PBACS_SYS_ALLOC};
	endproperty
	a_sysAlloc: assert property (p_sysAlloc) else $error("System allocated word wrong.");

	property p_accessHeader;
		s_readAt(PBACS_OFF_ACS_HDR) |=> s.rsp.rdata == (DOWNSTREAM ?
			{PBACS_NEXT_ACCESS, PBACS_CAP_VERSION, PBACS_ID_ACCESS} : 32'h0000_0000);
	endproperty
	a_accessHeader: assert property (p_accessHeader) else $error("Header wrong.");

	property p_accessFlags;
		s_readAt(PBACS_OFF_ACS_CAP) and DOWNSTREAM |=>
			s.rsp.rdata[15:0] == {PBACS_EGRESS_SIZE, 1'b0, PBACS_ACS_FLAGS};
	endproperty
	a_accessFlags: assert property (p_accessFlags) else $error("Flags wrong.");

	property p_enableWrite;
		s_writeAt(PBACS_OFF_ACS_CAP, 2) |=>
			acsEnable == (DOWNSTREAM ? $past(s.wData[22:16]) : PBACS_ENABLE_RST);
	endproperty
	a_enableWrite: assert property (p_enableWrite) else $error("Enable bits not written.");

	property p_egressWrite;
		s_writeAt(PBACS_OFF_EGRESS, 0) |=>
			egressVector == (DOWNSTREAM ? $past(s.wData[7:0]) : PBACS_EGRESS_RST);
	endproperty
	a_egressWrite: assert property (p_egressWrite) else $error("Egress not written.");

	property p_roStable;
		!(writeDone && isAt(s.awAddr, PBACS_OFF_ACS_CAP) && s.wStrb[2]) |=>
			$stable(acsEnable);
	endproperty
	a_roStable: assert property (p_roStable) else $error("Enables changed without write.");

	property p_reservedZero;
		s_readAt(PBACS_OFF_INDEX) |=> s.rsp.rdata[31:8] == 24'h000000;
	endproperty
	a_reservedZero: assert property (p_reservedZero) else $error("Reserved bits not zero.");

	// A completed write raises its answer one cycle later; that edge also lands the data.
	property p_writeAnswer;
		writeDone |=> s_writeAnswered;
	endproperty
	a_writeAnswer: assert property (p_writeAnswer) else $error("No write answer.");

	property p_readAnswer;
		s_readTaken |=> s_readHeld;
	endproperty
	a_readAnswer: assert property (p_readAnswer) else $error("No read answer.");

	// Unmapped words answer an error with zero data, so software never sees stale bits.
	property p_unmappedRead;
		s_readTaken and !isMapped(axiReq.araddr) |=>
			s.rsp.rdata == 32'h0000_0000 && s.rsp.rresp == PBACS_RESP_SLVERR;
	endproperty
	a_unmappedRead: assert property (p_unmappedRead) else $error("Unmapped read wrong.");

	property p_indexRead;
		s_readAt(PBACS_OFF_INDEX) |=> s.rsp.rdata[7:0] == $past(s.entryIndex);
	endproperty
	a_indexRead: assert property (p_indexRead) else $error("Index read wrong.");

	property p_indexStable;
		!(writeDone && isAt(s.awAddr, PBACS_OFF_INDEX) && s.wStrb[0]) |=>
			$stable(s.entryIndex);
	endproperty
	a_indexStable: assert property (p_indexStable) else $error("Index moved.");

	property p_enableRead;
		s_readAt(PBACS_OFF_ACS_CAP) |=> s.rsp.rdata[31:16] ==
			(DOWNSTREAM ? {9'h000, $past(s.acsEnable)} : 16'h0000);
	endproperty
	a_enableRead: assert property (p_enableRead) else $error("Enable read wrong.");

	property p_egressRead;
		s_readAt(PBACS_OFF_EGRESS) |=> s.rsp.rdata ==
			(DOWNSTREAM ? {24'h000000, $past(s.egressVector)} : 32'h0000_0000);
	endproperty
	a_egressRead: assert property (p_egressRead) else $error("Egress read wrong.");

	property p_egressStable;
		!(writeDone && isAt(s.awAddr, PBACS_OFF_EGRESS) && s.wStrb[0]) |=>
			$stable(egressVector);
	endproperty
	a_egressStable: assert property (p_egressStable) else $error("Egress moved.");

	// The upstream build keeps the routing settings idle whatever software writes.
	property p_upstreamIdle;
		!DOWNSTREAM |-> acsEnable == PBACS_ENABLE_RST && egressVector == PBACS_EGRESS_RST;
	endproperty
	a_upstreamIdle: assert property (p_upstreamIdle) else $error("Upstream not idle.");

	property p_upstreamCap;
		s_readAt(PBACS_OFF_ACS_CAP) and !DOWNSTREAM |=> s.rsp.rdata == 32'h0000_0000;
	endproperty
	a_upstreamCap: assert property (p_upstreamCap) else $error("Upstream word set.");

endmodule : pbacs_regs

// ### tb/tb_top.sv
// Bench for the power budget and access control registers, both port builds.
// Assumes the package compiled first; one master drives both builds alike.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
	import pbacs_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	pbacs_axi_req_t req = '0;
	pbacs_axi_rsp_t rsp, rspUp;
	logic [6:0] ens, ensUp;
	logic [7:0] egr, egrUp;
	int failures = 0;
	int checks_done = 0;
	logic [11:0] addrs [7] = '{12'h20c, 12'h210, 12'h214, 12'h218, 12'h220, 12'h224, 12'h228};
	// Expected words after reset, downstream then upstream build.
	logic [31:0] rstDn [7] = '{32'h22010004, 0, 32'h000b8004, 0, 32'h2401000d, 32'h0000087f, 0};
	logic [31:0] rstUp [7] = '{32'h23010004, 0, 32'h000b8004, 0, 0, 0, 0};
	// Expected words after all-ones writes; index ff zeroes the budget word.
	logic [31:0] wrDn [7] = '{32'h22010004, 32'hff, 0, 0, 32'h2401000d, 32'h007f087f, 32'hff};
	logic [31:0] wrUp [7] = '{32'h23010004, 32'hff, 0, 0, 0, 0, 0};
	logic [7:0] idx [4] = '{8'h00, 8'h01, 8'h02, 8'hff};
	logic [31:0] d, dUp;
	logic [1:0] resp, respUp;

	always #2 core_clk = ~core_clk;

	pbacs_regs #(.DOWNSTREAM(1'b1)) uut (.core_clk(core_clk), .rst(rst), .axiReq(req),
		.axiRsp(rsp), .acsEnable(ens), .egressVector(egr));
	pbacs_regs #(.DOWNSTREAM(1'b0)) uutUp (.core_clk(core_clk), .rst(rst), .axiReq(req),
		.axiRsp(rspUp), .acsEnable(ensUp), .egressVector(egrUp));

	// Prints the verdict; a hang or a finished sequence both end here.
	task automatic close_out();
		if (failures == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	// Offers address and data together and holds bready until the answer.
	task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
		int i;
		@(posedge core_clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= v;
		req.wstrb <= s;
		req.bready <= 1'b1;
		for (i = 0; i < 40; i++)
		begin
			@(posedge core_clk);
			if (req.awvalid && rsp.awready)
				req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready)
				req.wvalid <= 1'b0;
			if (rsp.bvalid)
			begin
				resp = rsp.bresp;
				respUp = rspUp.bresp;
				req.bready <= 1'b0;
				break;
			end
		end
		if (i == 40)
		begin
			failures++;
			close_out();
		end
	endtask : wr

	// One read; the upstream build answers in the same cycle as the downstream one.
	task automatic rd(input logic [11:0] a);
		int i;
		@(posedge core_clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		for (i = 0; i < 40; i++)
		begin
			@(posedge core_clk);
			if (req.arvalid && rsp.arready)
				req.arvalid <= 1'b0;
			if (rsp.rvalid)
			begin
				d = rsp.rdata;
				dUp = rspUp.rdata;
				resp = rsp.rresp;
				respUp = rspUp.rresp;
				req.rready <= 1'b0;
				break;
			end
		end
		if (i == 40)
		begin
			failures++;
			close_out();
		end
	endtask : rd

	// Main sequence: reset values, write masks, index decode, strobes, errors.
	initial
	begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		for (int k = 0; k < 7; k++)
		begin
			rd(addrs[k]);
			`CHK("reset dn", rstDn[k], d)
			`CHK("reset up", rstUp[k], dUp)
			`CHK("rresp", PBACS_RESP_OKAY, resp)
			`CHK("rresp up", PBACS_RESP_OKAY, respUp)
		end
		for (int k = 0; k < 7; k++)
		begin
			wr(addrs[k], 32'hffffffff, 4'hf);
			`CHK("bresp", PBACS_RESP_OKAY, resp)
			`CHK("bresp up", PBACS_RESP_OKAY, respUp)
		end
		for (int k = 0; k < 7; k++)
		begin
			rd(addrs[k]);
			`CHK("after wr dn", wrDn[k], d)
			`CHK("after wr up", wrUp[k], dUp)
		end
		`CHK("enables", 7'h7f, ens)
		`CHK("egress", 8'hff, egr)
		`CHK("enables up", 7'h00, ensUp)
		`CHK("egress up", 8'h00, egrUp)
		for (int k = 0; k < 4; k++)
		begin
			wr(PBACS_OFF_INDEX, {24'h0, idx[k]}, 4'h1);
			rd(PBACS_OFF_VALUE);
			`CHK("budget", (k < 2) ? 32'h000b8004 : 32'h0, d)
		end
		// Lane 2 carries the enables, so a write without it must not touch them.
		wr(PBACS_OFF_ACS_CAP, 32'h0, 4'hb);
		`CHK("enables kept", 7'h7f, ens)
		wr(PBACS_OFF_ACS_CAP, 32'h00550000, 4'h4);
		`CHK("enables set", 7'h55, ens)
		wr(PBACS_OFF_EGRESS, 32'h0000005a, 4'h1);
		`CHK("egress set", 8'h5a, egr)
		wr(12'h100, 32'hffffffff, 4'hf);
		`CHK("bresp unmapped", PBACS_RESP_SLVERR, resp)
		`CHK("bresp unmapped up", PBACS_RESP_SLVERR, respUp)
		rd(12'h100);
		`CHK("rresp unmapped", PBACS_RESP_SLVERR, resp)
		`CHK("rresp unmapped up", PBACS_RESP_SLVERR, respUp)
		`CHK("rdata unmapped", 32'h0, d)
		// A second reset in mid-run must bring the writable fields back.
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		`CHK("enables rst", 7'h00, ens)
		`CHK("egress rst", 8'h00, egr)
		rd(PBACS_OFF_INDEX);
		`CHK("index rst", 32'h0, d)
		close_out();
	end
endmodule : tb_top
